// *** rtl/sperr_top.sv ***
`timescale 1ns/1ps

// Operation
// (R1) parity flag sets on error, write-one clears
// (R2) two-bit field picks parity message severity
// (R3) parity report only on flag rising edge
// (R4) parity irq when enabled and upstream allows
// (R5) eight-bit parity counter saturates at 0xFF
// (R6) counter read returns value then clears
// (R7) enabled timeout discards over-age queued packets
// (R8) posted timeout report field, reset nonfatal
// (R9) non-posted timeout report field, reset none
// (R10) completion timeout report field, reset none
// (R11) check disable suppresses all parity errors
// (R12) timeout discard sets matching status bit
module sperr_top
    import sperr_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // error sources
    input  wire logic        parity_err_in,
    input  wire logic [2:0]  queue_overage,
    output logic      [2:0]  queue_discard,
    // upstream reporting
    input  wire logic        upstream_irq_enable,
    output logic             irq,
    output logic             msg_valid,
    output logic      [1:0]  msg_sev,
    output logic      [1:0]  msg_src,
    input  wire logic        msg_ready
);

    // ------------------------------
    // registers
    // ------------------------------
    logic        parity_check_disable;       // check off
    logic        parity_err_flag;            // sticky flag
    logic [1:0]  parity_err_report;          // severity field
    logic        parity_err_irq_enable;      // irq enable
    logic        queue_timeout_enable;       // discard enable
    logic [1:0]  posted_timeout_report;      // posted severity
    logic [1:0]  nonposted_timeout_report;   // non-posted severity
    logic [1:0]  completion_timeout_report;  // completion severity
    logic [2:0]  timeout_status_reg;         // sticky timeout bits
    logic [3:0]  irq_status;                 // sticky irq events
    logic [3:0]  irq_mask;                   // irq gate
    logic [7:0]  parity_err_counter;         // saturating count
    logic [7:0]  cnt_snap;                   // value returned by read

    // ------------------------------
    // bus decode
    // ------------------------------
    logic        setup;      // first cycle of a transfer
    logic        acc;        // completing access cycle
    logic        wr;         // write takes effect
    logic        rd;         // read completes
    logic [31:0] rdata_mux;  // read data before register
    logic        hit;        // address is mapped

    assign setup  = psel && !penable;
    assign acc    = psel && penable;
    assign pready = penable;            // zero wait in access phase
    assign wr     = acc && pwrite;
    assign rd     = acc && !pwrite;

    // address match helper
    function automatic logic is_reg(input logic [11:0] a,
                                    input logic [11:0] ofs);
        return a == ofs;
    endfunction : is_reg

    // one write strobe per register
    function automatic logic wr_to(input logic [11:0] ofs);
        return wr && is_reg(paddr, ofs);
    endfunction : wr_to

    // ------------------------------
    // error detection
    // ------------------------------
    logic       parity_hit;   // qualified parity error
    logic       flag_rise;    // flag goes 0 to 1
    logic [2:0] to_rise;      // timeout bits go 0 to 1

    assign parity_hit    = parity_err_in && !parity_check_disable; // R11
    assign flag_rise     = parity_hit && !parity_err_flag;        // R3
    assign queue_discard = queue_overage & {3{queue_timeout_enable}}; // R7
    assign to_rise       = queue_discard & ~timeout_status_reg;   // R12

    // ------------------------------
    // control registers
    // ------------------------------

    // parity check disable
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            parity_check_disable <= 1'b0;
        end else if (ce && wr_to(SPERR_PARITY_CTL_OFS)) begin
            parity_check_disable <= pwdata[SPERR_CHK_DIS_BIT];
        end
    end

    // parity reporting control
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            parity_err_report     <= SPERR_ERR_RPT_RST[1:0];          // R2
            parity_err_irq_enable <= SPERR_ERR_RPT_RST[SPERR_IRQ_EN_BIT];
        end else if (ce && wr_to(SPERR_ERR_RPT_OFS)) begin
            parity_err_report     <= pwdata[SPERR_RPT_LSB +: 2];      // R2
            parity_err_irq_enable <= pwdata[SPERR_IRQ_EN_BIT];
        end
    end

    // queue timeout enable
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            queue_timeout_enable <= SPERR_TO_CTL_RST[SPERR_TO_EN_BIT]; // R7
        end else if (ce && wr_to(SPERR_TO_CTL_OFS)) begin
            queue_timeout_enable <= pwdata[SPERR_TO_EN_BIT];
        end
    end

    // timeout reporting fields
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            posted_timeout_report     <= SPERR_TO_RPT_RST[SPERR_PTO_LSB +: 2];
            nonposted_timeout_report  <= SPERR_TO_RPT_RST[SPERR_NPTO_LSB +: 2];
            completion_timeout_report <= SPERR_TO_RPT_RST[SPERR_CTO_LSB +: 2];
        end else if (ce && wr_to(SPERR_TO_RPT_OFS)) begin
            posted_timeout_report     <= pwdata[SPERR_PTO_LSB +: 2];  // R8
            nonposted_timeout_report  <= pwdata[SPERR_NPTO_LSB +: 2]; // R9
            completion_timeout_report <= pwdata[SPERR_CTO_LSB +: 2];  // R10
        end
    end

    // interrupt mask
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            irq_mask <= SPERR_IRQ_MASK_RST[3:0];
        end else if (ce && wr_to(SPERR_IRQ_MASK_OFS)) begin
            irq_mask <= pwdata[3:0];
        end
    end

    // ------------------------------
    // sticky status
    // ------------------------------

    // parity flag, set wins over write-one clear
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            parity_err_flag <= 1'b0;
        end else if (ce) begin
            if (parity_hit) begin
                parity_err_flag <= 1'b1;                               // R1
            end else if (wr_to(SPERR_ERR_STS_OFS) &&
                         pwdata[SPERR_FLAG_BIT]) begin
                parity_err_flag <= 1'b0;                               // R1
            end
        end
    end

    // timeout status, set wins over clear
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            timeout_status_reg <= 3'h0;
        end else if (ce) begin
            if (wr_to(SPERR_TO_STS_OFS)) begin
                timeout_status_reg <= (timeout_status_reg & ~pwdata[2:0])
                                      | queue_discard;                 // R12
            end else begin
                timeout_status_reg <= timeout_status_reg | queue_discard; // R12
            end
        end
    end

    // irq events: parity when enabled, timeouts always
    logic [3:0] irq_set;
    assign irq_set = {queue_discard,
                      parity_hit && parity_err_irq_enable};            // R4

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            irq_status <= 4'h0;
        end else if (ce) begin
            if (wr_to(SPERR_IRQ_STS_OFS)) begin
                irq_status <= (irq_status & ~pwdata[3:0]) | irq_set;
            end else begin
                irq_status <= irq_status | irq_set;
            end
        end
    end

    // level interrupt, gated by upstream enable
    assign irq = |(irq_status & irq_mask) && upstream_irq_enable;      // R4

    // ------------------------------
    // parity counter
    // ------------------------------
    logic cnt_clr;  // read of the counter completes
    assign cnt_clr = rd && is_reg(paddr, SPERR_ERR_CNT_OFS);           // R6

    sperr_sat_cnt #(
        .W        (SPERR_CNT_W)
    ) u_cnt (
        .core_clk (core_clk),
        .resetn   (resetn),
        .ce       (ce),
        .inc      (parity_hit),                                        // R5
        .clr      (cnt_clr),
        .snap     (cnt_snap),
        .count    (parity_err_counter)
    );

    // ------------------------------
    // report generation
    // ------------------------------
    sperr_rpt_if rpt ();

    // source 0 parity, 1 posted, 2 non-posted, 3 completion
    assign rpt.raise = {to_rise, flag_rise};                           // R3
    assign rpt.sev   = {completion_timeout_report,                     // R10
                        nonposted_timeout_report,                      // R9
                        posted_timeout_report,                         // R8
                        parity_err_report};                            // R2

    sperr_msg_arb u_arb (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .ce        (ce),
        .rpt       (rpt),
        .msg_valid (msg_valid),
        .msg_sev   (msg_sev),
        .msg_src   (msg_src),
        .msg_ready (msg_ready)
    );

    // ------------------------------
    // read path
    // ------------------------------

    // read mux, reserved bits zero
    always_comb begin
        rdata_mux = 32'h0000_0000;
        hit       = 1'b1;
        case (paddr)
            SPERR_PARITY_CTL_OFS: rdata_mux[0] = parity_check_disable;
            SPERR_ERR_STS_OFS:    rdata_mux[0] = parity_err_flag;
            SPERR_ERR_RPT_OFS:    rdata_mux[2:0] = {parity_err_irq_enable,
                                                    parity_err_report};
            SPERR_ERR_CNT_OFS:    rdata_mux[7:0] = parity_err_counter;
            SPERR_TO_CTL_OFS:     rdata_mux[0] = queue_timeout_enable;
            SPERR_TO_RPT_OFS:     rdata_mux[5:0] = {completion_timeout_report,
                                                    nonposted_timeout_report,
                                                    posted_timeout_report};
            SPERR_TO_STS_OFS:     rdata_mux[2:0] = timeout_status_reg;
            SPERR_IRQ_STS_OFS:    rdata_mux[3:0] = irq_status;
            SPERR_IRQ_MASK_OFS:   rdata_mux[3:0] = irq_mask;
            default:              hit = 1'b0;
        endcase
    end

    // read data and error captured in setup cycle
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            prdata   <= 32'h0000_0000;
            pslverr  <= 1'b0;
            cnt_snap <= 8'h00;
        end else if (ce && setup) begin
            prdata   <= pwrite ? 32'h0000_0000 : rdata_mux;
            pslverr  <= !hit;
            cnt_snap <= parity_err_counter;                            // R6
        end
    end

endmodule : sperr_top

// *** rtl/sperr_pkg.sv ***
package sperr_pkg;

    // ------------------------------
    // register byte offsets
    // ------------------------------
    localparam logic [11:0] SPERR_PARITY_CTL_OFS  = 12'h04d4; // check off
    localparam logic [11:0] SPERR_ERR_STS_OFS     = 12'h04d8; // w1c flag
    localparam logic [11:0] SPERR_ERR_RPT_OFS     = 12'h04dc; // report ctl
    localparam logic [11:0] SPERR_ERR_CNT_OFS     = 12'h04e0; // rc counter
    localparam logic [11:0] SPERR_TO_CTL_OFS      = 12'h04e4; // discard en
    localparam logic [11:0] SPERR_TO_RPT_OFS      = 12'h04e8; // to report
    localparam logic [11:0] SPERR_TO_STS_OFS      = 12'h04f0; // w1c status
    localparam logic [11:0] SPERR_IRQ_STS_OFS     = 12'h04f4; // w1c events
    localparam logic [11:0] SPERR_IRQ_MASK_OFS    = 12'h04f8; // irq mask

    // ------------------------------
    // field positions
    // ------------------------------
    localparam int SPERR_CHK_DIS_BIT   = 0;  // parity check disable
    localparam int SPERR_FLAG_BIT      = 0;  // parity error flag
    localparam int SPERR_RPT_LSB       = 0;  // parity report field lsb
    localparam int SPERR_IRQ_EN_BIT    = 2;  // parity irq enable
    localparam int SPERR_TO_EN_BIT     = 0;  // queue timeout enable
    localparam int SPERR_PTO_LSB       = 0;  // posted report field
    localparam int SPERR_NPTO_LSB      = 2;  // non-posted report field
    localparam int SPERR_CTO_LSB       = 4;  // completion report field
    localparam int SPERR_CNT_W         = 8;  // parity counter width
    localparam int SPERR_NSRC          = 4;  // report sources

    // ------------------------------
    // reset values
    // ------------------------------
    localparam logic [31:0] SPERR_ERR_RPT_RST  = 32'h0000_0002;
    localparam logic [31:0] SPERR_TO_CTL_RST   = 32'h0000_0001;
    localparam logic [31:0] SPERR_TO_RPT_RST   = 32'h0000_0002;
    localparam logic [31:0] SPERR_IRQ_MASK_RST = 32'h0000_0001;
    localparam logic [7:0]  SPERR_CNT_MAX      = 8'hff;

    // ------------------------------
    // report severity encoding
    // ------------------------------
    typedef enum logic [1:0] {
        SPERR_SEV_NONE     = 2'h0,
        SPERR_SEV_COR      = 2'h1,
        SPERR_SEV_NONFATAL = 2'h2,
        SPERR_SEV_FATAL    = 2'h3
    } sperr_sev_t;

endpackage : sperr_pkg

// *** rtl/sperr_rpt_if.sv ***
`timescale 1ns/1ps
// raise pulses and their severities toward the message arbiter
interface sperr_rpt_if;
    import sperr_pkg::*;
    logic [SPERR_NSRC-1:0]   raise;  // one-cycle new-report pulses
    logic [2*SPERR_NSRC-1:0] sev;    // severity per source, 2 bits each
    modport src (output raise, output sev);
    modport arb (input raise, input sev);
endinterface : sperr_rpt_if

// *** rtl/sperr_sat_cnt.sv ***
`timescale 1ns/1ps
// saturating event counter with clear-on-read that keeps late events
module sperr_sat_cnt
    import sperr_pkg::*;
#(
    parameter int W = SPERR_CNT_W
) (
    input  wire logic         core_clk,
    input  wire logic         resetn,
    input  wire logic         ce,
    input  wire logic         inc,
    input  wire logic         clr,
    input  wire logic [W-1:0] snap,
    output logic      [W-1:0] count
);
    // refuse widths the counter cannot serve
    if (W < 1 || W > 32) begin : g_bad_w
        $error("sperr_sat_cnt: bad width");
    end

    logic [W-1:0] next_count;  // value after this edge
    logic [W-1:0] base;        // value left after a clear

    // clear removes only what the read returned
    always_comb begin
        base = clr ? count - snap : count;
        if (inc && base != {W{1'b1}}) begin
            next_count = base + 1'b1;
        end else begin
            next_count = base;
        end
    end

    // counter register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            count <= '0;
        end else if (ce) begin
            count <= next_count;
        end
    end
endmodule : sperr_sat_cnt

// *** rtl/sperr_msg_arb.sv ***
`timescale 1ns/1ps
// holds pending reports and sends them one at a time upstream
module sperr_msg_arb
    import sperr_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       ce,
    sperr_rpt_if.arb        rpt,
    output logic            msg_valid,
    output logic [1:0]      msg_sev,
    output logic [1:0]      msg_src,
    input  wire logic       msg_ready
);
    logic [SPERR_NSRC-1:0]   pend;       // reports waiting
    logic [2*SPERR_NSRC-1:0] pend_sev;   // their severities
    logic [SPERR_NSRC-1:0]   set_req;    // new, non-silent reports
    logic                    load;       // output slot free
    logic                    pick_ok;    // something to load
    logic [1:0]              pick;       // lowest pending index
    logic [SPERR_NSRC-1:0]   next_pend;

    // new report only when its severity is not none
    always_comb begin
        for (int i = 0; i < SPERR_NSRC; i++) begin
            set_req[i] = rpt.raise[i] && (rpt.sev[2*i +: 2] != SPERR_SEV_NONE);
        end
    end

    // lowest-index pending source wins
    always_comb begin
        pick    = 2'h0;
        pick_ok = 1'b0;
        for (int i = SPERR_NSRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                pick    = 2'(i);
                pick_ok = 1'b1;
            end
        end
        load = !msg_valid || msg_ready;
        next_pend = pend;
        if (load && pick_ok) begin
            next_pend[pick] = 1'b0;
        end
        next_pend = next_pend | set_req;   // set wins over grant
    end

    // pending bits and captured severities
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pend     <= '0;
            pend_sev <= '0;
        end else if (ce) begin
            pend <= next_pend;
            for (int i = 0; i < SPERR_NSRC; i++) begin
                if (set_req[i]) begin
                    pend_sev[2*i +: 2] <= rpt.sev[2*i +: 2];
                end
            end
        end
    end

    // message holding register, held until accepted
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            msg_valid <= 1'b0;
            msg_sev   <= 2'h0;
            msg_src   <= 2'h0;
        end else if (ce && load) begin
            msg_valid <= pick_ok;
            msg_sev   <= pend_sev[2*pick +: 2];
            msg_src   <= pick;
        end
    end
endmodule : sperr_msg_arb

// *** dv/sperr_top_sva.sv ***
`timescale 1ns/1ps
// watches the top ports for bus, message and gating relations
module sperr_top_sva
    import sperr_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [2:0]  queue_overage,
    input wire logic [2:0]  queue_discard,
    input wire logic        upstream_irq_enable,
    input wire logic        irq,
    input wire logic        msg_valid,
    input wire logic [1:0]  msg_sev,
    input wire logic [1:0]  msg_src,
    input wire logic        msg_ready
);
    // ------------------------------
    // helper state
    // ------------------------------
    logic to_en;  // mirrored discard enable
    logic mapped; // address hits a register
    logic acc;    // access edge of a transfer

    assign acc = psel && penable && ce;
    assign mapped = paddr inside {SPERR_PARITY_CTL_OFS, SPERR_ERR_STS_OFS,
        SPERR_ERR_RPT_OFS, SPERR_ERR_CNT_OFS, SPERR_TO_CTL_OFS,
        SPERR_TO_RPT_OFS, SPERR_TO_STS_OFS, SPERR_IRQ_STS_OFS,
        SPERR_IRQ_MASK_OFS};

    // mirror of the discard enable taken from bus writes
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            to_en <= 1'b1;
        end else if (acc && pwrite && paddr == SPERR_TO_CTL_OFS) begin
            to_en <= pwdata[SPERR_TO_EN_BIT];
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    // ------------------------------
    // assertions
    // ------------------------------
    a_ready_tracks: assert property (pready == penable)
        else $error("pready differs from penable");
    a_write_rdata: assert property (acc && pwrite |-> prdata == 32'h0)
        else $error("read data not zero on write");
    a_bad_addr: assert property (acc && !mapped |-> pslverr)
        else $error("unmapped access without slave error");
    a_good_addr: assert property (acc && mapped |-> !pslverr)
        else $error("slave error on mapped access");
    a_msg_hold: assert property (msg_valid && !msg_ready |=> msg_valid
        && $stable(msg_sev) && $stable(msg_src))
        else $error("message dropped before acceptance");
    a_sev_nonzero: assert property (msg_valid |-> msg_sev != 2'h0)
        else $error("message sent with none severity");
    a_irq_upstream: assert property (!upstream_irq_enable |-> !irq)
        else $error("irq high while upstream disabled");
    a_discard_gate: assert property (queue_discard ==
        (queue_overage & {3{to_en}}))
        else $error("discard not gated by enable");
    a_reset_quiet: assert property ($rose(resetn) |-> !msg_valid && !irq)
        else $error("activity right after reset");

    c_msg_taken: cover property (msg_valid && msg_ready);
    c_irq_rise: cover property ($rose(irq));
    c_slv_err: cover property (acc && pslverr);
endmodule : sperr_top_sva

bind sperr_top sperr_top_sva chk_u (.core_clk, .resetn, .ce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .queue_overage, .queue_discard, .upstream_irq_enable, .irq,
    .msg_valid, .msg_sev, .msg_src, .msg_ready);

// *** dv/sperr_root_model.sv ***
`timescale 1ns/1ps
// upstream root: takes messages promptly or slowly, logs each one
module sperr_root_model (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       stall,
    input  wire logic       msg_valid,
    input  wire logic [1:0] msg_sev,
    input  wire logic [1:0] msg_src,
    output logic            msg_ready
);
    logic [1:0] slow_cnt;  // paces acceptance while stalling
    logic [3:0] log_q[$];  // accepted {src, sev} entries

    // ready every cycle, or one cycle in four when stalling
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            msg_ready <= 1'b0;
            slow_cnt  <= 2'h0;
        end else begin
            if (msg_valid && msg_ready) begin
                log_q.push_back({msg_src, msg_sev});
            end
            slow_cnt  <= slow_cnt + 2'h1;
            msg_ready <= stall ? (slow_cnt == 2'h3) : 1'b1;
        end
    end
endmodule : sperr_root_model

// *** dv/switch_port_error_reporting_tb.sv ***
`timescale 1ns/1ps
// register and message level bench for the error reporting block
module switch_port_error_reporting_tb
    import sperr_pkg::*;
;
    logic core_clk = 0, resetn = 0, ce = 1;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq, msg_valid, msg_ready;
    logic parity_err_in = 0, upstream_irq_enable = 1, stall = 0;
    logic [2:0] queue_overage = 3'h0, queue_discard;
    logic [1:0] msg_sev, msg_src;
    int error_cnt = 0, checked = 0;

    always #2 core_clk = ~core_clk;

    sperr_top dut_u (.core_clk, .resetn, .ce, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .parity_err_in,
        .queue_overage, .queue_discard, .upstream_irq_enable, .irq,
        .msg_valid, .msg_sev, .msg_src, .msg_ready);
    sperr_root_model root_u (.core_clk, .resetn, .stall, .msg_valid,
        .msg_sev, .msg_src, .msg_ready);

    // ------------------------------
    // verdict, compare and bus tasks
    // ------------------------------
    task conclude;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk

    // one apb transfer, held until pready at an edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            conclude();
        end
        rd = prdata;
        psel <= 0; penable <= 0;
        @(posedge core_clk);
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    // read and compare the returned word
    task rc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rc

    // n back-to-back parity error cycles
    task par(input int n);
        parity_err_in <= 1;
        repeat (n) @(posedge core_clk);
        parity_err_in <= 0;
        @(posedge core_clk);
    endtask : par

    // bounded wait for n logged messages, then settle and count
    task msgs(input int n);
        int k;
        for (k = 0; k < 60 && root_u.log_q.size() < n; k++) begin
            @(posedge core_clk);
        end
        repeat (10) @(posedge core_clk);
        chk(root_u.log_q.size(), n);
    endtask : msgs

    // ------------------------------
    // main sequence
    // ------------------------------
    initial begin
        repeat (10) @(posedge core_clk);
        resetn <= 1;
        @(posedge core_clk);
        rc(SPERR_ERR_STS_OFS, 32'h0000_0000);
        rc(SPERR_ERR_RPT_OFS, 32'h0000_0002);
        rc(SPERR_TO_CTL_OFS, 32'h0000_0001);
        rc(SPERR_TO_RPT_OFS, 32'h0000_0002);
        rc(SPERR_IRQ_MASK_OFS, 32'h0000_0001);
        apb(1'b0, 12'hffc, 32'h0);
        chk(pslverr, 1'b1);
        // burst of three errors gives one report, count of three
        par(3);
        msgs(1);
        chk(root_u.log_q[0], 4'h2);
        rc(SPERR_ERR_CNT_OFS, 32'h0000_0003);
        rc(SPERR_ERR_CNT_OFS, 32'h0000_0000);
        wr(SPERR_ERR_STS_OFS, 32'h0000_0000);
        rc(SPERR_ERR_STS_OFS, 32'h0000_0001);
        wr(SPERR_ERR_STS_OFS, 32'h0000_0001);
        rc(SPERR_ERR_STS_OFS, 32'h0000_0000);
        chk(irq, 1'b0);
        // every severity code, none gives no message
        for (int s = 0; s < 4; s++) begin
            root_u.log_q.delete();
            wr(SPERR_ERR_RPT_OFS, s);
            par(1);
            msgs(s != 0);
            if (s != 0) chk(root_u.log_q[0], s);
            wr(SPERR_ERR_STS_OFS, 32'h0000_0001);
        end
        // interrupt raise, gate, mask and clear
        wr(SPERR_ERR_RPT_OFS, 32'h0000_0004);
        par(1);
        chk(irq, 1'b1);
        upstream_irq_enable <= 0;
        @(posedge core_clk);
        chk(irq, 1'b0);
        upstream_irq_enable <= 1;
        wr(SPERR_IRQ_MASK_OFS, 32'h0000_0000);
        chk(irq, 1'b0);
        wr(SPERR_IRQ_MASK_OFS, 32'h0000_000f);
        wr(SPERR_IRQ_STS_OFS, 32'h0000_000f);
        chk(irq, 1'b0);
        // counter stops at its top value
        apb(1'b0, SPERR_ERR_CNT_OFS, 32'h0);
        par(260);
        rc(SPERR_ERR_CNT_OFS, 32'h0000_00ff);
        // checking disabled: nothing is raised
        wr(SPERR_ERR_STS_OFS, 32'h0000_0001);
        wr(SPERR_PARITY_CTL_OFS, 32'h0000_0001);
        root_u.log_q.delete();
        par(2);
        rc(SPERR_ERR_STS_OFS, 32'h0000_0000);
        rc(SPERR_ERR_CNT_OFS, 32'h0000_0000);
        msgs(0);
        // all three queues time out at once, root stalls
        wr(SPERR_TO_RPT_OFS, 32'h0000_0036);
        stall <= 1;
        queue_overage <= 3'h7;
        #1 chk(queue_discard, 3'h7);
        @(posedge core_clk);
        queue_overage <= 3'h0;
        msgs(3);
        chk(root_u.log_q[0], 4'h6);
        chk(root_u.log_q[1], 4'h9);
        chk(root_u.log_q[2], 4'hf);
        stall <= 0;
        rc(SPERR_TO_STS_OFS, 32'h0000_0007);
        wr(SPERR_TO_STS_OFS, 32'h0000_0007);
        wr(SPERR_TO_CTL_OFS, 32'h0000_0000);
        queue_overage <= 3'h7;
        #1 chk(queue_discard, 3'h0);
        @(posedge core_clk);
        queue_overage <= 3'h0;
        rc(SPERR_TO_STS_OFS, 32'h0000_0000);
        conclude();
    end
endmodule : switch_port_error_reporting_tb
